/* File: sim/asop_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asop_host_model
(
    // clock and control
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [7:0] half,
    // strobe to the converter
    output logic sampleStrobe
);
    logic [7:0] cnt_r;
    // a stopped strobe parks low, as in a burst gap
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            {cnt_r, sampleStrobe} <= '0;
        else if (!run)
            {cnt_r, sampleStrobe} <= '0;
        else
        begin
            cnt_r <= (cnt_r == half) ? 8'h00 : cnt_r + 8'h01;
            sampleStrobe <= sampleStrobe ^ (cnt_r == half);
        end
    end
endmodule
`default_nettype wire

/* File: sim/asop_props.sv */
`timescale 1ns/10ps
`default_nettype none
module asop_props
    import asop_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // stimulus
    input wire logic sampleStrobe,
    input wire logic [MV_W-1:0] analogInPos,
    input wire logic [MV_W-1:0] analogInNeg,
    // results
    input wire logic [WORD_W-1:0] outputWord,
    input wire logic trackOnly,
    input wire logic outOfRange
);
    logic prevStb_r;
    logic [3:0] riseDly_r;
    logic [7:0] gap_r;
    logic rise;
    logic outside;
    int diff;
    assign rise = sampleStrobe & ~prevStb_r;
    assign diff = int'(analogInPos) - int'(analogInNeg);
    // window is 512 mV either side of the bias
    assign outside = diff < -512 || diff > 512;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            {prevStb_r, riseDly_r, gap_r} <= '0;
        else
        begin
            prevStb_r <= sampleStrobe;
            riseDly_r <= {riseDly_r[2:0], rise};
            gap_r <= rise ? 8'h00 : gap_r + 8'(gap_r != 8'hFF);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ********
    // properties
    // ********
    property p_delay;
        $changed(outputWord) |-> |riseDly_r[3:2];
    endproperty
    a_delay: assert property (p_delay) else $error("word off delay");
    property p_enter;
        outside |=> outOfRange;
    endproperty
    a_enter: assert property (p_enter) else $error("range missed");
    property p_recov;
        $past(nrst) && $past(outside) && !outside |=> outOfRange;
    endproperty
    a_recov: assert property (p_recov) else $error("no recovery");
    property p_done;
        !outside [*5] |-> !outOfRange;
    endproperty
    a_done: assert property (p_done) else $error("stuck");
    property p_slow;
        gap_r == 8'hAA |-> trackOnly;
    endproperty
    a_slow: assert property (p_slow) else $error("no track");
    property p_fast;
        rise && gap_r < 8'h96 |=> !trackOnly;
    endproperty
    a_fast: assert property (p_fast) else $error("track kept");
    property p_keep;
        trackOnly && !rise |=> trackOnly;
    endproperty
    a_keep: assert property (p_keep) else $error("track lost");
    property p_idle;
        !trackOnly && gap_r < 8'hA0 |=> !trackOnly;
    endproperty
    a_idle: assert property (p_idle) else $error("track early");
endmodule
bind asop_pipeline asop_props u_props (.clk, .nrst, .sampleStrobe, .analogInPos,
    .analogInNeg, .outputWord, .trackOnly, .outOfRange);
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import asop_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b1;
    logic [7:0] half = 8'h03;
    logic sampleStrobe;
    logic [MV_W-1:0] analogInPos = 13'h03E8;
    logic [MV_W-1:0] analogInNeg = 13'h03E8;
    logic [WORD_W-1:0] outputWord;
    logic trackOnly;
    logic outOfRange;
    logic lastStb = 1'b0;
    logic [8:0] cur = 9'h100;
    // pipeline resets to zero, so the first five words are zero
    logic [8:0] q[$] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000};
    int failCount = 0;
    int comparisons = 0;
    initial
    begin
        forever #2 clk = ~clk;
    end
    asop_pipeline dut (.clk, .nrst, .sampleStrobe, .analogInPos, .analogInNeg,
        .outputWord, .trackOnly, .outOfRange);
    asop_host_model host (.clk, .nrst, .run, .half, .sampleStrobe);
    // ********
    // tasks
    // ********
    task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // extreme codes are the ones a host may flag as saturation
    function automatic logic [8:0] sat(input logic [8:0] w);
        sat = 9'(w == 9'h000 || w == 9'h1FF);
    endfunction
    task automatic finishTest;
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // waits one strobe rise, then sets the level for the next sample
    task automatic step(input int d, input logic chk);
        int n;
        logic [8:0] e;
        for (n = 0; n < 400; n++)
        begin
            @(posedge clk);
            if (sampleStrobe && !lastStb)
                break;
            lastStb = sampleStrobe;
        end
        if (n == 400)
        begin
            failCount++;
            finishTest;
        end
        else
        begin
            lastStb = 1'b1;
            q.push_back(cur);
            e = q.pop_front();
            cur = d < -512 ? 9'h000 : d > 511 ? 9'h1FF : 9'((d + 512) >> 1);
            // common mode moves too, so only the difference may matter
            analogInNeg <= cur[0] ? 13'h0514 : 13'h03E8;
            analogInPos <= 13'((cur[0] ? 1300 : 1000) + d);
            repeat (5) @(posedge clk);
            if (chk)
            begin
                check("word", outputWord, e);
                check("sat", sat(outputWord), sat(e));
            end
            check("range", {8'h00, outOfRange}, {8'h00, d < -512 || d > 512});
        end
    endtask
    task automatic tCodes;
        int ds[10] = '{-512, -510, -256, -2, 0, 2, 256, 340, 510, 512};
        foreach (ds[i])
            step(ds[i], 1'b1);
    endtask
    task automatic tRange;
        int ds[8] = '{600, 513, 512, -513, -700, 0, 700, -100};
        foreach (ds[i])
            step(ds[i], 1'b1);
        repeat (5) step(0, 1'b1);
    endtask
    task automatic tBurst;
        run <= 1'b0;
        repeat (200) @(posedge clk);
        check("track", {8'h00, trackOnly}, 9'h001);
        run <= 1'b1;
        repeat (5) step(0, 1'b0);
        check("track", {8'h00, trackOnly}, 9'h000);
        repeat (6) step(-100, 1'b1);
    endtask
    // ********
    // run
    // ********
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        tCodes;
        tRange;
        tBurst;
        finishTest;
    end
endmodule
`default_nettype wire

/* File: verilog/asop_pipeline.sv */
// Contract
// - output word registered, each sample appears five strobe cycles later
// - new word valid one output delay after strobe rising edge
// - detect input outside nominal window, stop track-and-hold meanwhile
// - out of range holds all-zeros (under) or all-ones (over), never intermediate
// - back in range, valid conversions resume after about ten nanoseconds
// - strobe below about 1.5 MSPS switches track-and-hold to track only
// - capture analog value and start conversion on each strobe rising edge
// - result is one 9-bit parallel word, msb down to lsb
`timescale 1ns/10ps
`default_nettype none
module asop_pipeline
    import asop_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sample strobe from host
    input wire logic sampleStrobe,
    // analog input, millivolts
    input wire logic [MV_W-1:0] analogInPos,
    input wire logic [MV_W-1:0] analogInNeg,
    // output word
    output logic [WORD_W-1:0] outputWord,
    // status
    output logic trackOnly,
    output logic outOfRange
);
    // ********************************
    // quantizer
    // ********************************
    asop_quant_s quant;

    asop_quantizer uQuant
    (
        .analogInPos(analogInPos),
        .analogInNeg(analogInNeg),
        .quant(quant)
    );

    function automatic logic [WORD_W-1:0] satCode(input logic over);
        satCode = over ? CODE_FULL : CODE_ZERO;
    endfunction

    // ********************************
    // strobe edge and rate watch
    // ********************************
    logic strobeDly_r;
    logic strobeDly_nxt;
    logic [CNT_W-1:0] rateCnt_r;
    logic [CNT_W-1:0] rateCnt_nxt;
    logic trackOnly_r;
    logic trackOnly_nxt;
    logic strobeRise;

    assign strobeRise = sampleStrobe & ~strobeDly_r;

    always_comb
    begin
        strobeDly_nxt = sampleStrobe;
        rateCnt_nxt = rateCnt_r;
        trackOnly_nxt = trackOnly_r;
        if (strobeRise)
        begin
            // judged on the period just ended, so one slow gap flips the mode
            trackOnly_nxt = rateCnt_r >= CNT_W'(TRACK_ONLY_CYC);
            rateCnt_nxt = '0;
        end
        else if (rateCnt_r < CNT_W'(TRACK_ONLY_CYC))
        begin
            rateCnt_nxt = rateCnt_r + CNT_W'(1);
        end
        else
        begin
            trackOnly_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strobeDly_r <= 1'b0;
            rateCnt_r <= '0;
            trackOnly_r <= 1'b0;
        end
        else
        begin
            strobeDly_r <= strobeDly_nxt;
            rateCnt_r <= rateCnt_nxt;
            trackOnly_r <= trackOnly_nxt;
        end
    end

    // ********************************
    // out-of-range control
    // ********************************
    asop_range_e range_r;
    asop_range_e range_nxt;
    logic lockOver_r;
    logic lockOver_nxt;
    logic [CNT_W-1:0] recCnt_r;
    logic [CNT_W-1:0] recCnt_nxt;
    logic inputOut;

    assign inputOut = quant.underRange | quant.overRange;

    always_comb
    begin
        range_nxt = range_r;
        lockOver_nxt = lockOver_r;
        recCnt_nxt = recCnt_r;
        if (inputOut)
        begin
            lockOver_nxt = quant.overRange;
        end
        unique case (range_r)
            RANGE_OK:
            begin
                if (inputOut)
                begin
                    range_nxt = RANGE_OUT;
                end
            end
            RANGE_OUT:
            begin
                if (!inputOut)
                begin
                    range_nxt = RANGE_RECOVER;
                    recCnt_nxt = CNT_W'(RECOVER_CYC);
                end
            end
            RANGE_RECOVER:
            begin
                if (inputOut)
                begin
                    range_nxt = RANGE_OUT;
                end
                else if (recCnt_r <= CNT_W'(1))
                begin
                    range_nxt = RANGE_OK;
                end
                else
                begin
                    recCnt_nxt = recCnt_r - CNT_W'(1);
                end
            end
            default:
            begin
                range_nxt = RANGE_OUT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            range_r <= RANGE_OK;
            lockOver_r <= 1'b0;
            recCnt_r <= '0;
        end
        else
        begin
            range_r <= range_nxt;
            lockOver_r <= lockOver_nxt;
            recCnt_r <= recCnt_nxt;
        end
    end

    // ********************************
    // conversion pipeline and output
    // ********************************
    logic [WORD_W-1:0] sampleNow;
    logic [WORD_W-1:0] stage_r [PIPE_DEPTH];
    logic [WORD_W-1:0] stage_nxt [PIPE_DEPTH];
    logic [WORD_W-1:0] pend_r;
    logic [WORD_W-1:0] pend_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;
    logic [CNT_W-1:0] dlyCnt_r;
    logic [CNT_W-1:0] dlyCnt_nxt;

    // T/H shut off: locked extreme code, never a partial value
    always_comb
    begin
        if (inputOut || range_r != RANGE_OK)
        begin
            sampleNow = satCode(inputOut ? quant.overRange : lockOver_r);
        end
        else
        begin
            sampleNow = quant.code;
        end
    end

    always_comb
    begin
        stage_nxt = stage_r;
        pend_nxt = pend_r;
        word_nxt = word_r;
        dlyCnt_nxt = dlyCnt_r;
        if (strobeRise)
        begin
            stage_nxt[0] = sampleNow;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                stage_nxt[i] = stage_r[i-1];
            end
            // track only changes droop, not the word or its five-strobe latency
            pend_nxt = stage_r[PIPE_DEPTH-1];
            dlyCnt_nxt = CNT_W'(OUT_DELAY_CYC);
        end
        else if (dlyCnt_r != '0)
        begin
            dlyCnt_nxt = dlyCnt_r - CNT_W'(1);
            if (dlyCnt_r == CNT_W'(1))
            begin
                word_nxt = pend_r;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                stage_r[i] <= CODE_ZERO;
            end
            pend_r <= CODE_ZERO;
            word_r <= CODE_ZERO;
            dlyCnt_r <= '0;
        end
        else
        begin
            stage_r <= stage_nxt;
            pend_r <= pend_nxt;
            word_r <= word_nxt;
            dlyCnt_r <= dlyCnt_nxt;
        end
    end

    assign outputWord = word_r;
    assign trackOnly = trackOnly_r;
    assign outOfRange = range_r != RANGE_OK;
endmodule
`default_nettype wire

/* File: verilog/asop_pkg.sv */
package asop_pkg;

    // ********************************
    // word layout
    // ********************************
    localparam int WORD_W = 9;
    localparam int PIPE_DEPTH = 5;
    localparam logic [WORD_W-1:0] CODE_ZERO = 9'h000;
    localparam logic [WORD_W-1:0] CODE_FULL = 9'h1FF;

    // ********************************
    // analog model, millivolts
    // ********************************
    localparam int MV_W = 13;
    localparam int DIFF_W = 15;
    localparam logic signed [DIFF_W-1:0] BIAS_MV = 15'sh0CE4;
    localparam logic signed [DIFF_W-1:0] RANGE_LO_MV = 15'sh0AE4;
    localparam logic signed [DIFF_W-1:0] RANGE_HI_MV = 15'sh0EE4;
    localparam int MV_PER_LSB_SHIFT = 1;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OUT_DELAY_MAX_PS = 15000;
    localparam int RECOVER_PS = 10000;
    localparam int TRACK_ONLY_KSPS = 1500;
    localparam int PS_PER_KSPS_PERIOD = 1000000000;
    localparam int OUT_DELAY_CYC = OUT_DELAY_MAX_PS / CLK_PERIOD_PS;
    localparam int RECOVER_CYC = RECOVER_PS / CLK_PERIOD_PS;
    localparam int TRACK_ONLY_CYC = (PS_PER_KSPS_PERIOD / TRACK_ONLY_KSPS) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0]
    {
        RANGE_OK = 2'h0,
        RANGE_OUT = 2'h1,
        RANGE_RECOVER = 2'h3
    } asop_range_e;

    typedef struct packed
    {
        logic [WORD_W-1:0] code;
        logic underRange;
        logic overRange;
    } asop_quant_s;

endpackage

/* File: verilog/asop_quantizer.sv */
`timescale 1ns/10ps
`default_nettype none
module asop_quantizer
    import asop_pkg::*;
(
    // differential input, millivolts
    input wire logic [MV_W-1:0] analogInPos,
    input wire logic [MV_W-1:0] analogInNeg,
    // result
    output asop_quant_s quant
);
    logic signed [DIFF_W-1:0] level;
    logic signed [DIFF_W-1:0] offset;

    always_comb
    begin
        level = $signed({2'h0, analogInPos}) - $signed({2'h0, analogInNeg}) + BIAS_MV;
        offset = level - RANGE_LO_MV;
        quant.underRange = level < RANGE_LO_MV;
        quant.overRange = level > RANGE_HI_MV;
        if (quant.underRange)
        begin
            quant.code = CODE_ZERO;
        end
        else if (offset[DIFF_W-1:MV_PER_LSB_SHIFT] > (DIFF_W-MV_PER_LSB_SHIFT)'(CODE_FULL))
        begin
            quant.code = CODE_FULL;
        end
        else
        begin
            quant.code = offset[WORD_W-1+MV_PER_LSB_SHIFT:MV_PER_LSB_SHIFT];
        end
    end
endmodule
`default_nettype wire
